// ==== design/ilo_pkg.sv ====
// package: register map, field layout and pin carriers for the line block
// ****************************************************************
// ****************************************************************
package ilo_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] ILO_OFS_LINE_CTL = 8'h00;
   localparam logic [7:0] ILO_OFS_LINE_STATE = 8'h04;

   // ****************************************************************
   // field positions of bus_line_control
   // ****************************************************************
   localparam int ILO_BIT_BUS_BUSY = 7;
   localparam int ILO_BIT_START_STOP = 6;
   localparam int ILO_BIT_SDA_LEVEL = 5;
   localparam int ILO_BIT_SDA_GUARD = 4;
   localparam int ILO_BIT_SCL_MON = 3;
   localparam int ILO_BIT_RSVD2 = 2;
   localparam int ILO_BIT_CTRL_RST = 1;
   localparam int ILO_BIT_RSVD0 = 0;

   // ****************************************************************
   // reset values and fixed read values
   // ****************************************************************
   localparam logic ILO_RST_SDA_LEVEL = 1'b1;
   localparam logic ILO_RST_CTRL_RST = 1'b0;
   localparam logic ILO_READ_ONE = 1'b1;
   localparam int ILO_SYNC_STAGES = 2;

   // ****************************************************************
   // axi response codes
   // ****************************************************************
   localparam logic [1:0] ILO_RESP_OKAY = 2'h0;
   localparam logic [1:0] ILO_RESP_SLVERR = 2'h2;

   // ****************************************************************
   // pin carriers
   // ****************************************************************
   typedef struct packed {
      logic sda_oe;
      logic sda_o;
      logic scl_oe;
      logic scl_o;
   } ilo_pin_out_t;

   typedef struct packed {
      logic sda_i;
      logic scl_i;
   } ilo_pin_in_t;

endpackage

// ==== design/ilo_sync.sv ====
// two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module ilo_sync #(
   parameter int WIDTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   import ilo_pkg::*;

   // ****************************************************************
   // per bit chains; the first stage feeds only the second
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_q;
         logic stable_q;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_q <= 1'b1;
               stable_q <= 1'b1;
            end else begin
               meta_q <= async_in[gi];
               stable_q <= meta_q;
            end
         end
         assign sync_out[gi] = stable_q;
      end
   endgenerate

endmodule

// ==== design/ilo_line_ctl.sv ====
// line override and control-part reset register with axi4-lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ilo_line_ctl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ilo_pkg::ilo_pin_in_t pin_in,
   output ilo_pkg::ilo_pin_out_t pin_out,
   input wire logic xfer_sda_low,
   input wire logic xfer_scl_low,
   input wire logic bus_busy,
   output logic ctrl_reset,
   output logic sda_line_sync,
   output logic scl_line_sync
);
   import ilo_pkg::*;

   // ****************************************************************
   // register state
   // ****************************************************************
   logic sda_level_ctl_q;
   logic sda_level_ctl_d;
   logic ctrl_part_reset_q;
   logic ctrl_part_reset_d;

   // ****************************************************************
   // axi write path state
   // ****************************************************************
   logic aw_hold_q;
   logic w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   // ****************************************************************
   // axi read path state
   // ****************************************************************
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // ****************************************************************
   // line synchronisers
   // ****************************************************************
   logic [1:0] line_sync;

   ilo_sync #(
      .WIDTH(ILO_SYNC_STAGES)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({pin_in.sda_i, pin_in.scl_i}),
      .sync_out(line_sync)
   );

   assign sda_line_sync = line_sync[1];
   assign scl_line_sync = line_sync[0];

   // ****************************************************************
   // pin drive
   // ****************************************************************
   wire xfer_active_sda = xfer_sda_low & ~ctrl_part_reset_q;
   wire xfer_active_scl = xfer_scl_low & ~ctrl_part_reset_q;
   wire sda_drive = ~sda_level_ctl_q | xfer_active_sda;
   wire scl_drive = xfer_active_scl;
   wire sda_out_level = ~sda_drive;
   wire scl_out_level = ~scl_drive;

   assign pin_out.sda_oe = sda_drive;
   assign pin_out.sda_o = 1'b0;
   assign pin_out.scl_oe = scl_drive;
   assign pin_out.scl_o = 1'b0;

   // control logic outside sees a level reset while the bit is 1
   assign ctrl_reset = ctrl_part_reset_q;

   // ****************************************************************
   // write decode
   // ****************************************************************
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_hold_q | aw_hs;
   wire w_have = w_hold_q | w_hs;
   wire do_write = aw_have & w_have & ~bvalid_q;
   wire [7:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata;
   wire [3:0] wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
   wire wr_hit_ctl = wr_addr[7:2] == ILO_OFS_LINE_CTL[7:2];
   wire wr_hit_state = wr_addr[7:2] == ILO_OFS_LINE_STATE[7:2];
   wire wr_mapped = wr_hit_ctl | wr_hit_state;
   wire ctl_we = do_write & wr_hit_ctl & wr_strb[0];
   wire guard_open = ~wr_data[ILO_BIT_SDA_GUARD];
   wire level_we = ctl_we & guard_open;

   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready = ~w_hold_q & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ****************************************************************
   // register next values
   // ****************************************************************
   assign sda_level_ctl_d = level_we ? wr_data[ILO_BIT_SDA_LEVEL]
                                     : sda_level_ctl_q;
   assign ctrl_part_reset_d = ctl_we ? wr_data[ILO_BIT_CTRL_RST]
                                     : ctrl_part_reset_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sda_level_ctl_q <= ILO_RST_SDA_LEVEL;
         ctrl_part_reset_q <= ILO_RST_CTRL_RST;
      end else begin
         sda_level_ctl_q <= sda_level_ctl_d;
         ctrl_part_reset_q <= ctrl_part_reset_d;
      end
   end

   // ****************************************************************
   // write channel holding and response
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (do_write) begin
         aw_hold_q <= 1'b0;
      end else if (aw_hs) begin
         aw_hold_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (do_write) begin
         w_hold_q <= 1'b0;
      end else if (w_hs) begin
         w_hold_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= ILO_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_mapped ? ILO_RESP_OKAY : ILO_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // read decode
   // ****************************************************************
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire rd_hit_ctl = s_axi_araddr[7:2] == ILO_OFS_LINE_CTL[7:2];
   wire rd_hit_state = s_axi_araddr[7:2] == ILO_OFS_LINE_STATE[7:2];
   wire [7:0] ctl_view = {bus_busy,
                          ILO_READ_ONE,
                          sda_out_level,
                          ILO_READ_ONE,
                          scl_out_level,
                          ILO_READ_ONE,
                          ctrl_part_reset_q,
                          ILO_READ_ONE};
   wire [7:0] state_view = {6'h00, sda_line_sync, scl_line_sync};
   wire [31:0] rd_value = rd_hit_ctl ? {24'h00_0000, ctl_view} :
                          rd_hit_state ? {24'h00_0000, state_view} :
                          32'h0000_0000;
   wire [1:0] rd_resp = (rd_hit_ctl | rd_hit_state) ? ILO_RESP_OKAY
                                                    : ILO_RESP_SLVERR;

   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ILO_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_value;
         rresp_q <= rd_resp;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   guarded_write_a: assert property (
      level_we |=> sda_level_ctl_q == $past(wr_data[ILO_BIT_SDA_LEVEL]))
      else $error("level not taken on guarded write");

   guard_closed_a: assert property (
      (do_write && !(wr_hit_ctl && wr_strb[0] && guard_open))
      |=> $stable(sda_level_ctl_q))
      else $error("level changed without open guard");

   drive_low_a: assert property (
      (level_we && !wr_data[ILO_BIT_SDA_LEVEL])
      |=> pin_out.sda_oe && !pin_out.sda_o)
      else $error("data line not driven low");

   release_line_a: assert property (
      (level_we && wr_data[ILO_BIT_SDA_LEVEL] && !xfer_active_sda)
      ##1 !xfer_active_sda |-> !pin_out.sda_oe)
      else $error("data line not released");

   level_read_a: assert property (
      (ar_hs && rd_hit_ctl) |=>
      s_axi_rdata[ILO_BIT_SDA_LEVEL] == !$past(pin_out.sda_oe))
      else $error("level field does not match drive");

   fixed_ones_a: assert property (
      (rvalid_q && rresp_q == ILO_RESP_OKAY && $rose(rvalid_q)
       && $past(rd_hit_ctl))
      |-> s_axi_rdata[ILO_BIT_SDA_GUARD] && s_axi_rdata[ILO_BIT_RSVD2]
          && s_axi_rdata[ILO_BIT_RSVD0])
      else $error("fixed one bits read as zero");

   clock_monitor_a: assert property (
      (ar_hs && rd_hit_ctl) |=>
      s_axi_rdata[ILO_BIT_SCL_MON] == !$past(pin_out.scl_oe))
      else $error("clock monitor mismatch");

   ctrl_hold_a: assert property (
      ctrl_part_reset_q |-> ctrl_reset && !pin_out.scl_oe)
      else $error("control not held in reset");

   reset_keeps_level_a: assert property (
      (ctl_we && !guard_open && wr_data[ILO_BIT_CTRL_RST])
      |=> ctrl_reset && $stable(sda_level_ctl_q))
      else $error("control reset disturbed level field");

   write_answer_a: assert property (
      do_write |=> s_axi_bvalid
                   && (s_axi_bresp == ILO_RESP_OKAY) == $past(wr_mapped))
      else $error("write answer missing");

   write_hold_a: assert property (
      (s_axi_bvalid && !s_axi_bready)
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");

   read_answer_a: assert property (
      ar_hs |=> s_axi_rvalid && s_axi_rdata == $past(rd_value)
                && s_axi_rresp == $past(rd_resp))
      else $error("read answer missing");

   read_hold_a: assert property (
      (s_axi_rvalid && !s_axi_rready)
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped early");

   after_reset_a: assert property (
      $rose(aresetn) |-> sda_level_ctl_q && !ctrl_part_reset_q)
      else $error("wrong values after reset");

   ctrl_release_a: assert property (
      (ctl_we && !wr_data[ILO_BIT_CTRL_RST]) |=> !ctrl_reset)
      else $error("control reset not released");

   cov_drive_low_c: cover property (
      level_we && !wr_data[ILO_BIT_SDA_LEVEL] ##[1:20] level_we);
   cov_ctrl_reset_c: cover property (
      $rose(ctrl_part_reset_q) ##[1:20] $fell(ctrl_part_reset_q));
   cov_split_write_c: cover property (
      (aw_hs && !w_hs) ##[1:10] w_hs);
   cov_unmapped_c: cover property (
      rvalid_q && rresp_q == ILO_RESP_SLVERR);
   cov_held_xfer_c: cover property (
      ctrl_part_reset_q && xfer_sda_low);

endmodule

// ==== tb/ilo_bus_peer.sv ====
// bus peer model: other devices and pull-ups on the two lines
`timescale 1ns/1ps
module ilo_bus_peer (
   input wire logic sda_oe,
   input wire logic scl_oe,
   input wire logic pull_sda_low,
   input wire logic pull_scl_low,
   output ilo_pkg::ilo_pin_in_t pin_in
);
   import ilo_pkg::*;
   // ****************************************************************
   // wired-and lines: a released line is raised by its pull-up
   // ****************************************************************
   assign pin_in.sda_i = !(sda_oe || pull_sda_low);
   assign pin_in.scl_i = !(scl_oe || pull_scl_low);
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the line override and control reset register
`timescale 1ns/1ps
module testbench;
   import ilo_pkg::*;
   localparam logic [7:0] ctl = ILO_OFS_LINE_CTL;
   localparam logic [7:0] st = ILO_OFS_LINE_STATE;
   localparam logic [1:0] ok = ILO_RESP_OKAY;
   localparam logic [1:0] err = ILO_RESP_SLVERR;
   logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
   logic arvalid = '0, rready = '0, bus_busy = '0;
   logic xfer_sda_low = '0, xfer_scl_low = '0, peer_sda = '0, peer_scl = '0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, got;
   logic [3:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, ctrl_reset, sda_s, scl_s;
   logic [1:0] bresp, rresp, resp;
   ilo_pin_in_t pin_in;
   ilo_pin_out_t pin_out;
   int failures = 0, cmp_count = 0;

   ilo_line_ctl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
      .xfer_sda_low(xfer_sda_low), .xfer_scl_low(xfer_scl_low),
      .bus_busy(bus_busy), .ctrl_reset(ctrl_reset),
      .sda_line_sync(sda_s), .scl_line_sync(scl_s));
   ilo_bus_peer peer (.sda_oe(pin_out.sda_oe), .scl_oe(pin_out.scl_oe),
      .pull_sda_low(peer_sda), .pull_scl_low(peer_scl), .pin_in(pin_in));

   always #20 aclk = ~aclk;

   // ****************************************************************
   // compare, bus cycle and verdict tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // expected control word from busy, level, clock level, reset bit
   function automatic logic [31:0] cw(input logic [3:0] f);
      return {24'h0, f[3], 1'h1, f[2], 1'h1, f[1], 1'h1, f[0], 1'h1};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      logic aw_ok, w_ok, b_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      b_ok = 1'h0;
      resp = 2'bxx;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!b_ok) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'h1;
            awvalid <= 1'h0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'h1;
            wvalid <= 1'h0;
         end
         if (bvalid) begin
            b_ok = 1'h1;
            bready <= 1'h0;
            resp = bresp;
         end
      end
      chk("write response", {30'h0, er}, {30'h0, resp});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      logic r_ok;
      r_ok = 1'h0;
      resp = 2'bxx;
      got = 'x;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!r_ok) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) begin
            r_ok = 1'h1;
            rready <= 1'h0;
            got = rdata;
            resp = rresp;
         end
      end
      chk("read data", e, got);
      chk("read response", {30'h0, er}, {30'h0, resp});
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(ctl, cw(4'b0110), ok);
      rd(st, 32'h3, ok);
      chk("line sync", 32'h3, {sda_s, scl_s});
      chk("ctrl_reset", 32'h0, ctrl_reset);
      $display("test reset done");
      wr(ctl, 32'h10, 4'hf, ok);
      rd(ctl, cw(4'b0110), ok);
      wr(ctl, 32'h00, 4'h0, ok);
      rd(ctl, cw(4'b0110), ok);
      $display("test guard done");
      wr(ctl, 32'h00, 4'hf, ok);
      chk("sda_oe", 32'h1, pin_out.sda_oe);
      chk("sda_o", 32'h0, pin_out.sda_o);
      rd(ctl, cw(4'b0010), ok);
      rd(st, 32'h1, ok);
      wr(ctl, 32'h20, 4'hf, ok);
      chk("sda_oe", 32'h0, pin_out.sda_oe);
      rd(ctl, cw(4'b0110), ok);
      $display("test drive done");
      xfer_sda_low <= 1'h1;
      xfer_scl_low <= 1'h1;
      rd(ctl, cw(4'b0000), ok);
      chk("scl_oe", 32'h1, pin_out.scl_oe);
      chk("scl_o", 32'h0, pin_out.scl_o);
      wr(ctl, 32'h12, 4'hf, ok);
      chk("ctrl_reset", 32'h1, ctrl_reset);
      chk("scl_oe", 32'h0, pin_out.scl_oe);
      chk("sda_oe", 32'h0, pin_out.sda_oe);
      rd(ctl, cw(4'b0111), ok);
      wr(ctl, 32'h10, 4'hf, ok);
      chk("ctrl_reset", 32'h0, ctrl_reset);
      rd(ctl, cw(4'b0000), ok);
      xfer_sda_low <= 1'h0;
      xfer_scl_low <= 1'h0;
      $display("test control reset done");
      bus_busy <= 1'h1;
      peer_sda <= 1'h1;
      peer_scl <= 1'h1;
      repeat (3) @(posedge aclk);
      rd(ctl, cw(4'b1110), ok);
      rd(st, 32'h0, ok);
      chk("line sync", 32'h0, {sda_s, scl_s});
      bus_busy <= 1'h0;
      peer_sda <= 1'h0;
      peer_scl <= 1'h0;
      $display("test peer done");
      wr(8'h08, 32'h00, 4'hf, err);
      rd(ctl, cw(4'b0110), ok);
      rd(8'h08, 32'h0, err);
      $display("test unmapped done");
      wr(ctl, 32'h02, 4'hf, ok);
      chk("ctrl_reset", 32'h1, ctrl_reset);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      chk("ctrl_reset", 32'h0, ctrl_reset);
      chk("sda_oe", 32'h0, pin_out.sda_oe);
      rd(ctl, cw(4'b0110), ok);
      rd(st, 32'h3, ok);
      $display("test second reset done");
      print_verdict();
   end

   // watchdog: the whole sequence needs well under 300 cycles
   initial begin
      repeat (1000) @(posedge aclk);
      failures++;
      print_verdict();
   end
endmodule
